// ---- verilog/rpm_pkg.sv ----
// Purpose: shared constants and types for the rtc power management block
// Assumes: 40 MHz logic clock, rtc clock arrives as a pin level
// Notes:   register offset, field positions and timing counts live here
`default_nettype none
package rpm_pkg;
  // register map
  localparam logic [15:0] RPM_PWR_CTRL_ADDR = 16'h1930;
  localparam int          RPM_CLK_OUT_BIT   = 0;
  localparam int          RPM_REG_PD_BIT    = 1;
  localparam int          RPM_FULL_PD_BIT   = 2;
  localparam int          RPM_WAKE_DIR_BIT  = 3;
  localparam int          RPM_WAKE_OUT_BIT  = 4;
  localparam int          RPM_CTRL_W        = 5;
  localparam logic [4:0]  RPM_CTRL_RESET    = 5'h10;
  localparam logic [10:0] RPM_RSVD_VALUE    = 11'h000;

  // timing
  localparam int          RPM_CLK_HZ        = 40000000;
  localparam int          RPM_BG_CHARGE_MS  = 100;
  localparam int          RPM_BG_CHARGE_CYC = RPM_CLK_HZ / 1000
                                              * RPM_BG_CHARGE_MS;
  localparam int          RPM_CNT_W         = 23;
  localparam int          RPM_SYS_RST_NS    = 1000;
  localparam int          RPM_SYS_RST_CYC   = (RPM_SYS_RST_NS * 40
                                               + 999) / 1000;
  localparam logic [1:0]  RPM_WR_TICKS      = 2'h2;

  // synchroniser lanes
  localparam int          RPM_SYNC_W        = 3;
  localparam int          RPM_LANE_WAKE     = 0;
  localparam int          RPM_LANE_RTC_CLK  = 1;
  localparam int          RPM_LANE_CORE_OK  = 2;

  typedef enum logic [2:0] {
    RPM_RUN,
    RPM_DOWN,
    RPM_CHARGE,
    RPM_RAMP,
    RPM_RELEASE
  } rpm_state_t;

  function automatic logic rpm_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction
endpackage
`default_nettype wire

// ---- verilog/rpm_sync_if.sv ----
// Purpose: carries raw pin levels to the synchroniser and back synced
// Assumes: one clock domain
// Notes:   lanes are indexed by the lane constants of the package
`timescale 1ns/100ps
`default_nettype none
interface rpm_sync_if;
  import rpm_pkg::*;
  logic [RPM_SYNC_W-1:0] raw;
  logic [RPM_SYNC_W-1:0] synced;
  modport sync_end (input raw, output synced);
  modport user_end (output raw, input synced);
endinterface
`default_nettype wire

// ---- verilog/rpm_pin_sync.sv ----
// Purpose: two-stage synchroniser for every asynchronous pin of the block
// Assumes: lanes are independent levels
// Notes:   stage one feeds stage two only
`timescale 1ns/100ps
`default_nettype none
module rpm_pin_sync
  import rpm_pkg::*;
(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst_n,
  // pins in, levels out
  rpm_sync_if.sync_end  sif
);
  logic [RPM_SYNC_W-1:0] stage1_q;
  logic [RPM_SYNC_W-1:0] stage2_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= sif.raw;
      stage2_q <= stage1_q;
    end
  end

  assign sif.synced = stage2_q;
endmodule // rpm_pin_sync
`default_nettype wire

// ---- verilog/rpm_power_ctrl.sv ----
// Purpose: rtc domain power control register and rtc-only sequencing
// Assumes: rst_n is the rtc domain power-on reset; alarm from same clock
// Notes:   writes land two rtc clock ticks after the cpu strobe
// Notes on behaviour
// - Bits 15 to 5 of the control register read as zero, ignore writes.
// - Wake output value 0 pulls the wake pin low, 1 leaves it floating.
// - Wake direction 0 makes the pin an input, 1 an output.
// - As input the pin wakes on high; as output it is open-drain low.
// - The pin wakes the device from idle only while it is an input.
// - Full power-down turns off regulators, analog reset and bandgap.
// - Regulator power-down turns off regulators and reset, not bandgap.
// - A wake pin high or an rtc alarm brings the circuits back on.
// - After a full power-down the bandgap gets 100 ms before supplies.
// - Clock output enable gates the rtc clock output.
// - Either power-down drops the core regulator and supply ok.
// - Supply ok rises at the core threshold, resets system, frees cpu.
// - Register writes sync to the rtc clock, land two rtc ticks later.
// - Only the rtc power-on reset clears this block's flip-flops.
`timescale 1ns/100ps
`default_nettype none
module rpm_power_ctrl
  import rpm_pkg::*;
#(
  parameter int BG_CHARGE_CYC = RPM_BG_CHARGE_CYC
) (
  // clock and rtc power-on reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // cpu register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // rtc clock, alarm and core supply monitor
  input  wire logic        rtc_clk_pin,
  input  wire logic        rtc_alarm,
  input  wire logic        core_supply_at_threshold,
  output logic             rtc_clock_out,
  // wake pin
  input  wire logic        wake_pin_i,
  output logic             wake_pin_o,
  output logic             wake_pin_oe,
  output logic             idle_wake_req,
  // power controls
  output logic             core_regulator_en,
  output logic             analog_regulator_en,
  output logic             serial_bus_regulator_en,
  output logic             analog_por_en,
  output logic             bandgap_en,
  output logic             supply_ok_signal,
  output logic             rtc_isolate,
  output logic             system_reset_n,
  output logic             cpu_access_en
);
  rpm_sync_if sif ();

  // rtc flops only see rst_n; the device reset pin never reaches here
  rpm_pin_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .sif   (sif)
  );

  assign sif.raw[RPM_LANE_WAKE]    = wake_pin_i;
  assign sif.raw[RPM_LANE_RTC_CLK] = rtc_clk_pin;
  assign sif.raw[RPM_LANE_CORE_OK] = core_supply_at_threshold;

  logic wake_s;
  logic rtc_s;
  logic core_ok_s;
  assign wake_s    = sif.synced[RPM_LANE_WAKE];
  assign rtc_s     = sif.synced[RPM_LANE_RTC_CLK];
  assign core_ok_s = sif.synced[RPM_LANE_CORE_OK];

  // register write path
  logic [RPM_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [RPM_CTRL_W-1:0] pend_q, pend_d;
  logic                  pend_v_q, pend_v_d;
  logic [1:0]            ticks_q, ticks_d;
  logic                  rtc_prev_q;
  logic                  rtc_tick;
  logic                  addr_hit;
  logic                  wake_req;

  // sequencer
  rpm_state_t            state_q, state_d;
  logic                  full_q, full_d;
  logic [RPM_CNT_W-1:0]  cnt_q, cnt_d;

  // registered outputs
  logic [15:0] rdata_q, rdata_d;
  logic        regs_on_q, regs_on_d;
  logic        bg_on_q, bg_on_d;
  logic        ok_q, ok_d;
  logic        iso_q, iso_d;
  logic        sysrst_n_q, sysrst_n_d;
  logic        oe_q, oe_d;
  logic        idle_q, idle_d;
  logic        clk_out_q, clk_out_d;

  assign rtc_tick = rpm_rise(rtc_s, rtc_prev_q);
  assign addr_hit = (reg_addr == RPM_PWR_CTRL_ADDR);
  // wake is taken on an rtc tick, so a pulse of one rtc period is caught
  assign wake_req = (rtc_tick & wake_s
                     & ~ctrl_q[RPM_WAKE_DIR_BIT]) | rtc_alarm;

  always_comb begin
    ctrl_d   = ctrl_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    ticks_d  = ticks_q;
    rdata_d  = rdata_q;
    // cpu is fenced off while isolated
    if (reg_wr && addr_hit && ok_q) begin
      pend_d   = reg_wdata[RPM_CTRL_W-1:0];
      pend_v_d = 1'b1;
      ticks_d  = 2'h0;
    end else if (pend_v_q && rtc_tick) begin
      if (ticks_q == RPM_WR_TICKS - 2'h1) begin
        ctrl_d   = pend_q;
        pend_v_d = 1'b0;
        ticks_d  = 2'h0;
      end else begin
        ticks_d = ticks_q + 2'h1;
      end
    end
    // power-down bits drop once the wake is taken
    if (state_q == RPM_DOWN && wake_req) begin
      ctrl_d[RPM_REG_PD_BIT]  = 1'b0;
      ctrl_d[RPM_FULL_PD_BIT] = 1'b0;
    end
    if (reg_rd) begin
      rdata_d = (addr_hit && ok_q)
                ? {RPM_RSVD_VALUE, ctrl_q} : 16'h0000;
    end
  end

  always_comb begin
    state_d    = state_q;
    full_d     = full_q;
    cnt_d      = cnt_q;
    regs_on_d  = 1'b1;
    bg_on_d    = 1'b1;
    ok_d       = ok_q;
    sysrst_n_d = 1'b1;
    case (state_q)
      RPM_RUN: begin
        if (ctrl_q[RPM_REG_PD_BIT] || ctrl_q[RPM_FULL_PD_BIT]) begin
          state_d   = RPM_DOWN;
          full_d    = ctrl_q[RPM_FULL_PD_BIT];
          regs_on_d = 1'b0;
          bg_on_d   = ~ctrl_q[RPM_FULL_PD_BIT];
          ok_d      = 1'b0;
        end
      end
      RPM_DOWN: begin
        regs_on_d = 1'b0;
        bg_on_d   = ~full_q;
        ok_d      = 1'b0;
        if (wake_req) begin
          cnt_d = '0;
          if (full_q) begin
            state_d   = RPM_CHARGE;
            bg_on_d   = 1'b1;
          end else begin
            state_d   = RPM_RAMP;
            regs_on_d = 1'b1;
          end
        end
      end
      RPM_CHARGE: begin
        // regulators wait until the reference has settled
        regs_on_d = 1'b0;
        if (cnt_q == RPM_CNT_W'(BG_CHARGE_CYC - 1)) begin
          state_d   = RPM_RAMP;
          regs_on_d = 1'b1;
          cnt_d     = '0;
        end else begin
          cnt_d = cnt_q + RPM_CNT_W'(1);
        end
      end
      RPM_RAMP: begin
        if (core_ok_s) begin
          state_d    = RPM_RELEASE;
          ok_d       = 1'b1;
          sysrst_n_d = 1'b0;
          cnt_d      = '0;
        end
      end
      RPM_RELEASE: begin
        sysrst_n_d = 1'b0;
        if (cnt_q == RPM_CNT_W'(RPM_SYS_RST_CYC - 1)) begin
          state_d    = RPM_RUN;
          sysrst_n_d = 1'b1;
        end else begin
          cnt_d = cnt_q + RPM_CNT_W'(1);
        end
      end
      default: begin
        state_d = RPM_RAMP;
        ok_d    = 1'b0;
      end
    endcase
    // open-drain: only ever pulls low, floats otherwise
    oe_d      = ctrl_q[RPM_WAKE_DIR_BIT]
                & ~ctrl_q[RPM_WAKE_OUT_BIT];
    idle_d    = wake_s & ~ctrl_q[RPM_WAKE_DIR_BIT];
    // own flop so isolation is glitch-free at the pin
    iso_d     = ~ok_d;
    clk_out_d = rtc_s & ctrl_q[RPM_CLK_OUT_BIT];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= RPM_CTRL_RESET;
      pend_q     <= RPM_CTRL_RESET;
      pend_v_q   <= 1'b0;
      ticks_q    <= 2'h0;
      rtc_prev_q <= 1'b0;
      state_q    <= RPM_RAMP;
      full_q     <= 1'b0;
      cnt_q      <= '0;
      rdata_q    <= 16'h0000;
      regs_on_q  <= 1'b1;
      bg_on_q    <= 1'b1;
      ok_q       <= 1'b0;
      iso_q      <= 1'b1;
      sysrst_n_q <= 1'b0;
      oe_q       <= 1'b0;
      idle_q     <= 1'b0;
      clk_out_q  <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      pend_q     <= pend_d;
      pend_v_q   <= pend_v_d;
      ticks_q    <= ticks_d;
      rtc_prev_q <= rtc_s;
      state_q    <= state_d;
      full_q     <= full_d;
      cnt_q      <= cnt_d;
      rdata_q    <= rdata_d;
      regs_on_q  <= regs_on_d;
      bg_on_q    <= bg_on_d;
      ok_q       <= ok_d;
      iso_q      <= iso_d;
      sysrst_n_q <= sysrst_n_d;
      oe_q       <= oe_d;
      idle_q     <= idle_d;
      clk_out_q  <= clk_out_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign core_regulator_en       = regs_on_q;
  assign analog_regulator_en     = regs_on_q;
  assign serial_bus_regulator_en = regs_on_q;
  assign analog_por_en           = regs_on_q;
  assign bandgap_en              = bg_on_q;
  assign supply_ok_signal        = ok_q;
  assign rtc_isolate             = iso_q;
  assign cpu_access_en           = ok_q;
  assign system_reset_n          = sysrst_n_q;
  assign wake_pin_o              = 1'b0;   // open-drain drives only low
  assign wake_pin_oe             = oe_q;
  assign idle_wake_req           = idle_q;
  assign rtc_clock_out           = clk_out_q;

  // checks
  rsvd_read_zero_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_rd |=> reg_rdata[15:RPM_CTRL_W] == RPM_RSVD_VALUE)
    else $error("reserved bits read nonzero");

  wake_drive_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wake_pin_oe |-> $past(ctrl_q[RPM_WAKE_DIR_BIT])
                    && !$past(ctrl_q[RPM_WAKE_OUT_BIT]))
    else $error("wake pin driven without output low setting");

  idle_wake_dir_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    idle_wake_req |-> !$past(ctrl_q[RPM_WAKE_DIR_BIT]))
    else $error("idle wake while pin is an output");

  full_pd_off_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == RPM_DOWN && full_q) |-> !bandgap_en && !core_regulator_en)
    else $error("full power-down left circuits on");

  reg_pd_bg_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == RPM_DOWN && !full_q) |-> bandgap_en && !analog_por_en)
    else $error("regulator power-down state wrong");

  bg_charge_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == RPM_DOWN && full_q && wake_req)
      |=> !core_regulator_en [*8])
    else $error("regulators on before bandgap charged");

  pd_drops_ok_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state_q == RPM_RUN && (ctrl_q[RPM_REG_PD_BIT]
                            || ctrl_q[RPM_FULL_PD_BIT]))
      |=> !supply_ok_signal && rtc_isolate)
    else $error("power-down did not isolate");

  ok_release_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(supply_ok_signal) |-> !system_reset_n && $past(core_ok_s))
    else $error("supply ok rose without threshold or reset");

  write_delay_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(ctrl_q) && state_q == RPM_RUN && $past(state_q) == RPM_RUN
      |-> $past(pend_v_q) && $past(rtc_tick) && $past(ticks_q) == 2'h1)
    else $error("register changed before two rtc ticks");
endmodule // rpm_power_ctrl
`default_nettype wire

// ---- tb/rpm_ext_power.sv ----
// Purpose: outside power manager: rtc crystal, core supply, wake driver
// Assumes: rtc clock sped up so a run stays short
// Notes:   outside driver holds the wake line low between pulses
`timescale 1ns/100ps
`default_nettype none
module rpm_ext_power #(
  parameter int RTC_HALF = 20,
  parameter int RAMP_CYC = 30
) (
  // clock
  input  wire logic clock,
  // device side
  input  wire logic core_regulator_en,
  input  wire logic wake_pin_oe,
  output logic      rtc_clk_pin,
  output logic      core_supply_at_threshold,
  output logic      wake_lvl
);
  int   half_cnt = 0;
  int   ramp_cnt = 0;
  logic drive_hi = 1'b0;
  initial rtc_clk_pin = 1'b0;
  initial core_supply_at_threshold = 1'b0;
  // crystal keeps running through every power mode
  always @(posedge clock) begin
    half_cnt <= (half_cnt == RTC_HALF - 1) ? 0 : half_cnt + 1;
    if (half_cnt == RTC_HALF - 1) rtc_clk_pin <= ~rtc_clk_pin;
  end
  // supply needs a ramp after the regulator turns on
  always @(posedge clock) begin
    if (!core_regulator_en) ramp_cnt <= 0;
    else if (ramp_cnt < RAMP_CYC) ramp_cnt <= ramp_cnt + 1;
    core_supply_at_threshold <= core_regulator_en && ramp_cnt >= RAMP_CYC;
  end
  // the device pull-down wins over the outside driver
  assign wake_lvl = wake_pin_oe ? 1'b0 : drive_hi;
  // used with supplies up or powered down; pulse lasts two rtc periods
  task automatic wake_pulse();
    @(posedge clock);
    drive_hi <= 1'b1;
    repeat (4 * RTC_HALF) @(posedge clock);
    drive_hi <= 1'b0;
  endtask
endmodule // rpm_ext_power
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the rtc power control block
// Assumes: short bandgap charge count and fast rtc clock
// Notes:   reads are queued by the driver and checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rpm_pkg::*;
  localparam int BG_CYC = 20;
  localparam int RTC_HALF = 20;
  localparam int LIMIT = 20000;
  logic        clock, rst_n, reg_wr, reg_rd, rtc_alarm, rtc_clk, sup_th;
  logic        wake_lvl, clk_out, oe, idle, core_en, ana_en, usb_en, por_en;
  logic        bg_en, ok, iso, sys_rst_n, cpu_en, seen, tog, prev;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, lfsr, e;
  logic [4:0]  cur;
  logic [4:0]  vals [4] = '{5'h09, 5'h18, 5'h01, 5'h10};
  logic [1:0]  rd_p = 2'b00;
  logic [15:0] exp_q [$];
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;

  rpm_power_ctrl #(.BG_CHARGE_CYC(BG_CYC)) uut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rtc_clk_pin(rtc_clk), .rtc_alarm(rtc_alarm),
    .core_supply_at_threshold(sup_th), .rtc_clock_out(clk_out),
    .wake_pin_i(wake_lvl), .wake_pin_o(), .wake_pin_oe(oe),
    .idle_wake_req(idle), .core_regulator_en(core_en),
    .analog_regulator_en(ana_en), .serial_bus_regulator_en(usb_en),
    .analog_por_en(por_en), .bandgap_en(bg_en), .supply_ok_signal(ok),
    .rtc_isolate(iso), .system_reset_n(sys_rst_n), .cpu_access_en(cpu_en));
  rpm_ext_power #(.RTC_HALF(RTC_HALF)) ext (
    .clock(clock), .core_regulator_en(core_en), .wake_pin_oe(oe),
    .rtc_clk_pin(rtc_clk), .core_supply_at_threshold(sup_th),
    .wake_lvl(wake_lvl));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check16(input string nm, input logic [15:0] x,
                         input logic [15:0] y);
    check_count++;
    if (x !== y) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic check1(input string nm, input logic x, input logic y);
    check_count++;
    if (x !== y) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, x, y);
    end
  endtask

  task automatic reg_read(input logic [15:0] a, input logic [15:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(x);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  // the old value must still read back right after the write
  task automatic reg_write(input logic [4:0] v);
    lfsr = lfsr_next(lfsr);
    @(posedge clock);
    reg_addr <= RPM_PWR_CTRL_ADDR;
    reg_wdata <= {lfsr[15:5], v};
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_read(RPM_PWR_CTRL_ADDR, {11'h000, cur});
    repeat (6 * RTC_HALF + 10) @(posedge clock);
  endtask

  task automatic wait_ok();
    for (int i = 0; i < 400 && ok !== 1'b1; i++) @(posedge clock);
    check1("supply ok", 1'b1, ok);
    check1("isolate", 1'b0, iso);
    check1("cpu access", 1'b1, cpu_en);
    check1("system reset", 1'b0, sys_rst_n);
    repeat (45) @(posedge clock);
  endtask

  task automatic power_down(input logic [4:0] v);
    reg_write(v);
    check1("supply ok", 1'b0, ok);
    check1("isolate", 1'b1, iso);
    check1("regulators", 1'b0, core_en | ana_en | usb_en | por_en);
    check1("bandgap", ~v[2], bg_en);
  endtask

  always @(posedge clock) rd_p <= {rd_p[0], reg_rd};
  always @(negedge clock) begin
    if (rd_p[1]) begin
      e = exp_q.pop_front();
      check16("read data", e, reg_rdata);
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; rtc_alarm = 1'b0;
    reg_addr = 16'h0000; reg_wdata = 16'h0000; lfsr = 16'h26A7;
    cur = 5'h10;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check1("isolate", 1'b1, iso);
    wait_ok();
    reg_read(RPM_PWR_CTRL_ADDR, 16'h0010);
    reg_read(16'h1931, 16'h0000);
    foreach (vals[i]) begin
      reg_write(vals[i]);
      cur = vals[i];
      reg_read(RPM_PWR_CTRL_ADDR, {11'h000, cur});
      check1("wake drive", cur[3] & ~cur[4], oe);
      seen = 1'b0;
      tog = 1'b0;
      prev = clk_out;
      fork
        ext.wake_pulse();
        repeat (4 * RTC_HALF + 10) begin
          @(posedge clock);
          seen |= idle;
          tog |= (clk_out !== prev);
          prev = clk_out;
        end
      join
      check1("idle wake", ~cur[3], seen);
      check1("clock out", cur[0], tog);
    end
    power_down(5'h12);
    // supply ok may rise while the pulse is still high
    fork
      ext.wake_pulse();
      begin
        for (int i = 0; i < 100 && core_en !== 1'b1; i++) @(posedge clock);
        check1("regulators", 1'b1, core_en & ana_en & usb_en & por_en);
        wait_ok();
      end
    join
    reg_read(RPM_PWR_CTRL_ADDR, 16'h0010);
    power_down(5'h14);
    @(posedge clock);
    rtc_alarm <= 1'b1;
    @(posedge clock);
    rtc_alarm <= 1'b0;
    for (int i = 0; i < 50 && bg_en !== 1'b1; i++) @(posedge clock);
    for (n = 0; n < 100 && core_en !== 1'b1; n++) @(posedge clock);
    check1("bandgap charge", 1'b1, n >= BG_CYC - 1 && n <= BG_CYC + 1);
    wait_ok();
    reg_read(RPM_PWR_CTRL_ADDR, 16'h0010);
    repeat (4) @(posedge clock);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
